// [ddir_pkg.sv]
/*
 * Shared definitions for the device and die identity register bank:
 * register byte addresses, field layouts, reset values and the internal
 * bus access carrier.
 * Assumes a 32-bit APB slave port and a single clock domain.
 */
package ddir_pkg;

    // ---------------------------------------------------------------
    // Register byte addresses
    // ---------------------------------------------------------------
    localparam logic [31:0] DDIR_OFS_IDENT = 32'h0fffff78;
    localparam logic [31:0] DDIR_OFS_DIE_LOW = 32'h0fffff7c;
    localparam logic [31:0] DDIR_OFS_DIE_HIGH = 32'h0fffff80;
    localparam logic [31:0] DDIR_OFS_CTRL = 32'h0fffff84;
    localparam logic [31:0] DDIR_OFS_STAT = 32'h0fffff88;

    // ---------------------------------------------------------------
    // Fixed identity field values
    // ---------------------------------------------------------------
    localparam logic DDIR_COPROC_PRESENT = 1'h1;
    localparam logic [3:0] DDIR_PROCESS_CODE = 4'h5;
    localparam logic DDIR_IO_VOLT_3V3 = 1'h0;
    localparam logic DDIR_PERIPH_PARITY = 1'h1;
    localparam logic [1:0] DDIR_PROG_MEM_ECC = 2'h2;
    localparam logic DDIR_DATA_RAM_ECC = 1'h1;

    // ---------------------------------------------------------------
    // Control and status field positions, reset values
    // ---------------------------------------------------------------
    localparam int unsigned DDIR_CTRL_ERR_EN_BIT = 0;
    localparam int unsigned DDIR_CTRL_RECAP_BIT = 1;
    localparam int unsigned DDIR_STAT_VALID_BIT = 0;
    localparam int unsigned DDIR_STAT_UNMAP_BIT = 1;
    localparam int unsigned DDIR_STAT_CNT_CLR_BIT = 2;
    localparam int unsigned DDIR_STAT_CNT_LSB = 8;
    localparam int unsigned DDIR_CNT_W = 8;
    localparam logic DDIR_ERR_EN_RST = 1'h0;
    localparam logic [7:0] DDIR_CNT_RST = 8'h00;
    localparam logic [7:0] DDIR_CNT_MAX = 8'hff;
    localparam logic [31:0] DDIR_WORD_RST = 32'h00000000;
    localparam logic [63:0] DDIR_FUSE_RST = 64'h0000000000000000;

    // ---------------------------------------------------------------
    // Field layouts
    // ---------------------------------------------------------------
    typedef struct packed {
        logic coproc_present;
        logic [13:0] die_config_number;
        logic [3:0] process_code;
        logic io_volt_class;
        logic periph_parity;
        logic [1:0] prog_mem_prot;
        logic data_ram_ecc;
        logic [4:0] revision;
        logic [2:0] platform_tag;
    } ddir_ident_t;

    typedef struct packed {
        logic [7:0] wafer_num;
        logic [11:0] y_coord;
        logic [11:0] x_coord;
    } ddir_die_low_t;

    typedef struct packed {
        logic [7:0] reserved;
        logic [23:0] lot_num;
    } ddir_die_high_t;

    typedef struct packed {
        logic setup;
        logic access;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } ddir_access_t;

endpackage

// [ddir_apb_front.sv]
/*
 * APB phase decoder for the identity bank: splits a transfer into its
 * setup and access cycles and answers every access with no wait state.
 * Assumes a well-behaved APB master on the same clock.
 */
`timescale 1ns/1ps
module ddir_apb_front (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output ddir_pkg::ddir_access_t acc,
    output logic pready
);
    import ddir_pkg::*;

    // ---------------------------------------------------------------
    // Phase decode
    // ---------------------------------------------------------------
    // Read data is fetched during setup, so the access can end at once
    wire logic setup_w = psel & ~penable;
    wire logic access_w = psel & penable;

    assign acc.setup = setup_w;
    assign acc.access = access_w;
    assign acc.write = pwrite;
    assign acc.addr = paddr;
    assign acc.wdata = pwdata;
    assign acc.strb = pstrb;
    assign pready = access_w;

endmodule // ddir_apb_front

// [ddir_fuse_latch.sv]
/*
 * Holds the 64-bit die trace record taken from the fuse bits.
 * The fuses are sampled one cycle after reset release and again on a
 * recapture request; they are assumed settled by then.
 */
`timescale 1ns/1ps
module ddir_fuse_latch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [63:0] fuse_bits,
    input wire logic recapture,
    output logic [63:0] trace_q,
    output logic valid_q
);
    import ddir_pkg::*;

    logic pending_q;
    wire logic take_w = pending_q | recapture;

    // ---------------------------------------------------------------
    // Capture
    // ---------------------------------------------------------------
    // Reset loads only constants; the fuse level is taken after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_q <= 1'h1;
            valid_q <= 1'h0;
            trace_q <= DDIR_FUSE_RST;
        end else if (take_w) begin
            pending_q <= 1'h0;
            valid_q <= 1'h1;
            trace_q <= fuse_bits;
        end
    end

endmodule // ddir_fuse_latch

// [ddir_regs.sv]
/*
 * Device and die identity register bank, top level.
 * Holds a fixed identification word, a 64-bit die trace record whose low 56 bits
 * are split over two words, and a small control and status pair, all on APB.
 * Assumes one 40 MHz clock, asynchronous active-low reset, and die
 * trace fuse bits that are stable once reset is released.
 */
`timescale 1ns/1ps
module ddir_regs #(
    // Arbitrary neutral value, not a real configuration code
    parameter logic [13:0] DIE_CONFIG_NUMBER = 14'h1a5b,
    // Arbitrary neutral value, not a real family code
    parameter logic [2:0] PLATFORM_TAG = 3'h3,
    parameter logic [4:0] SILICON_REV = 5'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] die_fuse_bits
);
    import ddir_pkg::*;

    // ---------------------------------------------------------------
    // Bus front end
    // ---------------------------------------------------------------
    ddir_access_t acc;

    ddir_apb_front u_front (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .acc(acc),
        .pready(pready)
    );

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    wire logic hit_ident = (acc.addr == DDIR_OFS_IDENT);
    wire logic hit_die_low = (acc.addr == DDIR_OFS_DIE_LOW);
    wire logic hit_die_high = (acc.addr == DDIR_OFS_DIE_HIGH);
    wire logic hit_ctrl = (acc.addr == DDIR_OFS_CTRL);
    wire logic hit_stat = (acc.addr == DDIR_OFS_STAT);

    // The three identity words share the write-ignore behaviour
    wire logic hit_ro = hit_ident | hit_die_low | hit_die_high;
    wire logic hit_any = hit_ro | hit_ctrl | hit_stat;
    wire logic unmapped = ~hit_any;

    // ---------------------------------------------------------------
    // Access strobes
    // ---------------------------------------------------------------
    // Writes take effect only at the edge that completes the access
    wire logic wr_stb = acc.access & acc.write;
    wire logic rd_setup = acc.setup & ~acc.write;

    wire logic wr_ctrl = wr_stb & hit_ctrl & acc.strb[0];
    wire logic wr_stat = wr_stb & hit_stat & acc.strb[0];
    wire logic wr_ro = wr_stb & hit_ro;
    wire logic acc_unmapped = acc.access & unmapped;

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    logic err_en_q;
    logic err_en_d;

    assign err_en_d = wr_ctrl ?
        acc.wdata[DDIR_CTRL_ERR_EN_BIT] : err_en_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_en_q <= DDIR_ERR_EN_RST;
        end else begin
            err_en_q <= err_en_d;
        end
    end

    // Recapture is a one-cycle request; the bit never reads back as one
    wire logic recapture = wr_ctrl & acc.wdata[DDIR_CTRL_RECAP_BIT];

    // ---------------------------------------------------------------
    // Die trace record
    // ---------------------------------------------------------------
    logic [63:0] trace_q;
    logic trace_valid_q;

    ddir_fuse_latch u_fuse (
        .pclk(pclk),
        .presetn(presetn),
        .fuse_bits(die_fuse_bits),
        .recapture(recapture),
        .trace_q(trace_q),
        .valid_q(trace_valid_q)
    );

    ddir_die_low_t die_low;
    ddir_die_high_t die_high;

    // Low word carries the wafer position, high word the lot
    assign die_low.x_coord = trace_q[11:0];
    assign die_low.y_coord = trace_q[23:12];
    assign die_low.wafer_num = trace_q[31:24];
    assign die_high.lot_num = trace_q[55:32];
    // Reserved byte reads zero whatever the fuses hold
    assign die_high.reserved = 8'h00;

    // ---------------------------------------------------------------
    // Identification word
    // ---------------------------------------------------------------
    ddir_ident_t ident;

    assign ident.coproc_present = DDIR_COPROC_PRESENT;
    assign ident.die_config_number = DIE_CONFIG_NUMBER;
    assign ident.process_code = DDIR_PROCESS_CODE;
    assign ident.io_volt_class = DDIR_IO_VOLT_3V3;
    assign ident.periph_parity = DDIR_PERIPH_PARITY;
    assign ident.prog_mem_prot = DDIR_PROG_MEM_ECC;
    assign ident.data_ram_ecc = DDIR_DATA_RAM_ECC;
    assign ident.revision = SILICON_REV;
    assign ident.platform_tag = PLATFORM_TAG;

    // ---------------------------------------------------------------
    // Unmapped access flag
    // ---------------------------------------------------------------
    logic unmap_q;
    logic unmap_d;

    // A new stray access in the clearing cycle keeps the flag set
    assign unmap_d = acc_unmapped |
        (unmap_q & ~(wr_stat & acc.wdata[DDIR_STAT_UNMAP_BIT]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unmap_q <= 1'h0;
        end else begin
            unmap_q <= unmap_d;
        end
    end

    // ---------------------------------------------------------------
    // Ignored write counter
    // ---------------------------------------------------------------
    // Counts writes aimed at identity words, so software can see that
    // a stray write arrived; it saturates rather than wrapping
    logic [7:0] ign_cnt_q;
    logic [7:0] ign_cnt_d;
    wire logic cnt_clr = wr_stat & acc.wdata[DDIR_STAT_CNT_CLR_BIT];
    wire logic cnt_full = (ign_cnt_q == DDIR_CNT_MAX);

    assign ign_cnt_d = cnt_clr ? DDIR_CNT_RST :
        (wr_ro & ~cnt_full) ? ign_cnt_q + 8'h01 : ign_cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ign_cnt_q <= DDIR_CNT_RST;
        end else begin
            ign_cnt_q <= ign_cnt_d;
        end
    end

    // ---------------------------------------------------------------
    // Read words
    // ---------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    always_comb begin
        ctrl_word = DDIR_WORD_RST;
        ctrl_word[DDIR_CTRL_ERR_EN_BIT] = err_en_q;
    end

    always_comb begin
        stat_word = DDIR_WORD_RST;
        stat_word[DDIR_STAT_VALID_BIT] = trace_valid_q;
        stat_word[DDIR_STAT_UNMAP_BIT] = unmap_q;
        stat_word[DDIR_STAT_CNT_LSB +: DDIR_CNT_W] = ign_cnt_q;
    end

    // ---------------------------------------------------------------
    // Read data select
    // ---------------------------------------------------------------
    // Identity words are pure functions of constants and the trace
    // record, so no write to them changes them; a recapture write reloads the die words
    wire logic [31:0] rd_ident = ident;
    wire logic [31:0] rd_low = die_low;
    wire logic [31:0] rd_high = die_high;

    wire logic [31:0] rd_word =
        hit_ident ? rd_ident :
        hit_die_low ? rd_low :
        hit_die_high ? rd_high :
        hit_ctrl ? ctrl_word :
        hit_stat ? stat_word : DDIR_WORD_RST;

    // ---------------------------------------------------------------
    // Read data register
    // ---------------------------------------------------------------
    // Loaded in the setup cycle so the zero-wait access sees it from a
    // flip-flop; it holds between transfers
    logic [31:0] prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= DDIR_WORD_RST;
        end else if (rd_setup) begin
            prdata_q <= rd_word;
        end
    end

    assign prdata = prdata_q;

    // ---------------------------------------------------------------
    // Error response
    // ---------------------------------------------------------------
    // Only a stray address may raise an error, and only when enabled;
    // writes to the identity words always complete cleanly
    assign pslverr = acc_unmapped & err_en_q;

endmodule // ddir_regs

// [ddir_regs_assertions.sv]
/*
 * Checker for the identity register bank, bound to ddir_regs.
 * Assumes die fuse bits change only just before a recapture request.
 */
`timescale 1ns/1ps
module ddir_regs_checker import ddir_pkg::*; #(
    parameter logic [13:0] DIE_CONFIG_NUMBER = 14'h1a5b,
    parameter logic [2:0] PLATFORM_TAG = 3'h3,
    parameter logic [4:0] SILICON_REV = 5'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [63:0] die_fuse_bits
);
    // ----
    // Helpers
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic ro_hit = paddr == DDIR_OFS_IDENT ||
        paddr == DDIR_OFS_DIE_LOW || paddr == DDIR_OFS_DIE_HIGH;
    wire logic ro_wr = psel && penable && pwrite && ro_hit;
    sequence s_rd(logic [31:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    // ----
    // Properties
    // ----
    property p_ident_hi;
        s_rd(DDIR_OFS_IDENT) |=>
            prdata[31:13] == {1'h1, DIE_CONFIG_NUMBER, 4'h5};
    endproperty
    a_ident_hi: assert property (p_ident_hi)
        else $error("ident upper fields wrong");
    property p_ident_lo;
        s_rd(DDIR_OFS_IDENT) |=> prdata[12:0] ==
            {1'h0, 1'h1, 2'h2, 1'h1, SILICON_REV, PLATFORM_TAG};
    endproperty
    a_ident_lo: assert property (p_ident_lo)
        else $error("ident lower fields wrong");
    // Reads at the first edge after reset legally return zero
    property p_die_low;
        s_rd(DDIR_OFS_DIE_LOW) ##0 $past(presetn) |=>
            prdata == die_fuse_bits[31:0];
    endproperty
    a_die_low: assert property (p_die_low)
        else $error("die low word wrong");
    property p_die_lot;
        s_rd(DDIR_OFS_DIE_HIGH) ##0 $past(presetn) |=>
            prdata[23:0] == die_fuse_bits[55:32];
    endproperty
    a_die_lot: assert property (p_die_lot)
        else $error("die lot number wrong");
    property p_die_rsvd;
        s_rd(DDIR_OFS_DIE_HIGH) |=> prdata[31:24] == 8'h00;
    endproperty
    a_die_rsvd: assert property (p_die_rsvd)
        else $error("die reserved byte not zero");
    property p_ro_rd_ok;
        s_rd(DDIR_OFS_IDENT) ##1 penable |-> pready && !pslverr;
    endproperty
    a_ro_rd_ok: assert property (p_ro_rd_ok)
        else $error("ident read not completed cleanly");
    property p_ro_wr_ok;
        ro_wr |-> pready && !pslverr;
    endproperty
    a_ro_wr_ok: assert property (p_ro_wr_ok)
        else $error("write to read-only word flagged error");
    property p_ro_wr_quiet;
        ro_wr |=> $stable(prdata);
    endproperty
    a_ro_wr_quiet: assert property (p_ro_wr_quiet)
        else $error("write to read-only word disturbed read data");
    c_ident: cover property (s_rd(DDIR_OFS_IDENT));
    c_die_high: cover property (s_rd(DDIR_OFS_DIE_HIGH));
    c_err: cover property (psel && penable && pslverr);
endmodule // ddir_regs_checker

bind ddir_regs ddir_regs_checker #(
    .DIE_CONFIG_NUMBER(DIE_CONFIG_NUMBER),
    .PLATFORM_TAG(PLATFORM_TAG),
    .SILICON_REV(SILICON_REV)
) ddir_regs_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .die_fuse_bits(die_fuse_bits)
);

// [ddir_regs_bench.sv]
/*
 * Self-checking bench for the identity register bank.
 * Assumes the checker is bound in; the bench is the only APB master.
 */
`timescale 1ns/1ps
module ddir_regs_bench;
    import ddir_pkg::*;
    // Arbitrary neutral identity values
    localparam logic [13:0] CFG = 14'h2c71;
    localparam logic [2:0] TAG = 3'h6;
    localparam logic [4:0] REV = 5'h0b;
    localparam logic [31:0] IDENT_EXP =
        {1'h1, CFG, 4'h5, 1'h0, 1'h1, 2'h2, 1'h1, REV, TAG};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, wd, ex;
    logic [3:0] pstrb;
    logic [63:0] fuse;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int errors = 0;
    int checked = 0;
    // ----
    // Design and clock
    // ----
    ddir_regs #(.DIE_CONFIG_NUMBER(CFG), .PLATFORM_TAG(TAG),
        .SILICON_REV(REV)) ddir_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .die_fuse_bits(fuse)
    );
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    // ----
    // Checking
    // ----
    task automatic check_val(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Each completed access takes the oldest note: {check data, err, data}
    always @(posedge pclk) begin
        if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("[ERR] access expected none seen one");
            end else begin
                e = exp_q.pop_front();
                check_val("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
                if (e[33])
                    check_val("prdata", prdata, e[31:0]);
            end
        end
    end
    // ----
    // APB master
    // ----
    task automatic apb(input logic wr, input logic [31:0] a, d, x,
        input logic cd, ce);
        exp_q.push_back({cd, ce, x});
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Only the watchdog ends a wait that never completes
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (3000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h1463204c));
        fuse = {$urandom(), $urandom()};
        presetn = 1'h0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        apb(1'h0, DDIR_OFS_IDENT, 32'h0, IDENT_EXP, 1'h1, 1'h0);
        $display("test ident done");
        apb(1'h0, DDIR_OFS_DIE_LOW, 32'h0, fuse[31:0], 1'h1, 1'h0);
        apb(1'h0, DDIR_OFS_DIE_HIGH, 32'h0, {8'h00, fuse[55:32]},
            1'h1, 1'h0);
        $display("test die done");
        for (int i = 0; i < 3; i++) begin
            wd = $urandom();
            ex = i == 0 ? IDENT_EXP : i == 1 ? fuse[31:0] :
                {8'h00, fuse[55:32]};
            paddr <= paddr;
            apb(1'h1, DDIR_OFS_IDENT + 4 * i, wd, 32'h0, 1'h0, 1'h0);
            apb(1'h0, DDIR_OFS_IDENT + 4 * i, 32'h0, ex, 1'h1, 1'h0);
        end
        // Ignored writes are counted in status bits 15:8
        apb(1'h0, DDIR_OFS_STAT, 32'h0, 32'h00000301, 1'h1, 1'h0);
        $display("test read-only writes done");
        apb(1'h1, DDIR_OFS_CTRL, 32'h00000001, 32'h0, 1'h0, 1'h0);
        apb(1'h1, DDIR_OFS_IDENT, $urandom(), 32'h0, 1'h0, 1'h0);
        apb(1'h0, 32'h0fffff8c, 32'h0, 32'h0, 1'h1, 1'h1);
        apb(1'h0, DDIR_OFS_STAT, 32'h0, 32'h00000403, 1'h1, 1'h0);
        $display("test error enable done");
        @(posedge pclk);
        fuse <= {$urandom(), $urandom()};
        apb(1'h1, DDIR_OFS_CTRL, 32'h00000003, 32'h0, 1'h0, 1'h0);
        // Trace updates at the edge that completes the write; keep reads clear of it
        @(posedge pclk);
        apb(1'h0, DDIR_OFS_DIE_LOW, 32'h0, fuse[31:0], 1'h1, 1'h0);
        apb(1'h0, DDIR_OFS_DIE_HIGH, 32'h0, {8'h00, fuse[55:32]},
            1'h1, 1'h0);
        $display("test recapture done");
        // Recapture bit reads back as zero, enable stays set
        apb(1'h0, DDIR_OFS_CTRL, 32'h0, 32'h00000001, 1'h1, 1'h0);
        // A status write without the low byte strobe must be ignored
        pstrb <= 4'h0;
        apb(1'h1, DDIR_OFS_STAT, 32'h00000006, 32'h0, 1'h0, 1'h0);
        pstrb <= 4'hf;
        apb(1'h0, DDIR_OFS_STAT, 32'h0, 32'h00000403, 1'h1, 1'h0);
        apb(1'h1, DDIR_OFS_STAT, 32'h00000006, 32'h0, 1'h0, 1'h0);
        apb(1'h0, DDIR_OFS_STAT, 32'h0, 32'h00000001, 1'h1, 1'h0);
        $display("test status clear done");
        repeat (2) @(posedge pclk);
        tally_and_finish();
    end
endmodule // ddir_regs_bench
